// ==== prc_pkg.sv ====
/*
 * Shared constants for the PLL and core regulator control block:
 * register addresses, field positions, reset values and the level decode.
 * Assumes the control port delivers whole registers in one access.
 */
package prc_pkg;

   // register addresses on the control port
   localparam logic [15:0] PRC_ADDR_REGULATOR = 16'h4001;
   localparam logic [15:0] PRC_ADDR_PLL = 16'h4002;

   localparam int PRC_PLL_W = 48;
   localparam int PRC_REG_W = 8;

   // pll parameter register fields
   localparam int PLL_DEN_MSB = 47;
   localparam int PLL_DEN_MID = 40;
   localparam int PLL_DEN_LSB = 32;
   localparam int PLL_NUM_MSB = 31;
   localparam int PLL_NUM_MID = 24;
   localparam int PLL_NUM_LSB = 16;
   localparam int PLL_INT_MSB = 14;
   localparam int PLL_INT_LSB = 11;
   localparam int PLL_XDIV_MSB = 10;
   localparam int PLL_XDIV_LSB = 9;
   localparam int PLL_TYPE_BIT = 8;
   localparam int PLL_LOCK_BIT = 1;
   localparam int PLL_EN_BIT = 0;

   // regulator register field
   localparam int REG_LVL_MSB = 2;
   localparam int REG_LVL_LSB = 1;

   // reset values
   localparam logic [15:0] PLL_DEN_RST = 16'h0753;
   localparam logic [15:0] PLL_NUM_RST = 16'h0287;
   localparam logic [3:0] PLL_INT_RST = 4'h3;
   localparam logic [1:0] PLL_XDIV_RST = 2'h0;
   localparam logic PLL_TYPE_RST = 1'h1;
   localparam logic PLL_EN_RST = 1'h1;
   localparam logic PLL_LOCK_RST = 1'h0;
   localparam logic [1:0] REG_LVL_RST = 2'h1;

   // legal integer multiplier codes
   localparam logic [3:0] PLL_INT_MIN = 4'h2;
   localparam logic [3:0] PLL_INT_MAX = 4'h8;

   localparam int PRC_SYNC_STAGES = 2;

   typedef enum logic
   {
      PRC_LOOP_INTEGER = 1'b0,
      PRC_LOOP_FRACTIONAL = 1'b1
   } prc_loop_e;

   typedef logic [10:0] prc_mv_t;

   // core supply target in millivolts for a level code
   function automatic prc_mv_t prc_level_mv(input logic [1:0] code);
      case (code)
         2'h0: prc_level_mv = 11'h5dc;
         2'h1: prc_level_mv = 11'h578;
         2'h2: prc_level_mv = 11'h640;
         2'h3: prc_level_mv = 11'h6a4;
         default: prc_level_mv = 11'h578;
      endcase
   endfunction

endpackage

// ==== prc_ratio.sv ====
/*
 * Feedback ratio decoder: turns the programmed fields into the divider
 * setting the loop uses. Purely combinational; the top registers it.
 */
`timescale 1ns/1ps
module prc_ratio
   import prc_pkg::*;
(
   // programmed fields in, decoded setting out
   prc_ratio_if.calc rif
);

   always_comb
   begin
      rif.eff_int = rif.r_code;
      rif.x_val = 3'({1'b0, rif.x_code}) + 3'h1;
      if (rif.frac == PRC_LOOP_FRACTIONAL)
      begin
         // output = (ref / x) * (r + n / m)
         rif.eff_num = rif.n_num;
         rif.eff_den = rif.m_den;
      end
      else
      begin
         // integer loop: fraction forced to zero over a harmless denominator
         rif.eff_num = 16'h0000;
         rif.eff_den = 16'h0001;
      end
      // a zero denominator would stall the fractional accumulator
      rif.ok = (rif.r_code >= PLL_INT_MIN) && (rif.r_code <= PLL_INT_MAX)
         && ((rif.frac != PRC_LOOP_FRACTIONAL) || (rif.m_den != 16'h0000));
   end

endmodule

// ==== prc_ratio_if.sv ====
/*
 * Carrier between the register file and the feedback ratio decoder.
 * Assumes both ends share the control clock; it holds no logic.
 */
`timescale 1ns/1ps
interface prc_ratio_if;
   // programmed fields
   logic [3:0] r_code;
   logic [1:0] x_code;
   logic frac;
   logic [15:0] m_den;
   logic [15:0] n_num;
   // decoded feedback setting
   logic [3:0] eff_int;
   logic [15:0] eff_num;
   logic [15:0] eff_den;
   logic [2:0] x_val;
   logic ok;

   modport cfg
   (
      output r_code, x_code, frac, m_den, n_num,
      input eff_int, eff_num, eff_den, x_val, ok
   );
   modport calc
   (
      input r_code, x_code, frac, m_den, n_num,
      output eff_int, eff_num, eff_den, x_val, ok
   );
endinterface

// ==== prc_top.sv ====
/*
 * PLL parameter and core regulator level control with sticky lock status.
 * Assumes a whole-register control port on ref_clk and a lock level from
 * the analog loop that is asynchronous to ref_clk.
 */
`timescale 1ns/1ps
module prc_top
   import prc_pkg::*;
#(
   parameter int SYNC_STAGES = PRC_SYNC_STAGES
)
(
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ce,
   // control port, whole registers per access
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [47:0] reg_wdata,
   input wire logic reg_rd,
   output logic [47:0] reg_rdata,
   output logic reg_rvalid,
   // analog loop status, asynchronous
   input wire logic loop_locked,
   // loop controls
   output logic pll_run,
   output logic pll_frac,
   output logic [2:0] pll_in_div,
   output logic [3:0] pll_fb_int,
   output logic [15:0] pll_fb_num,
   output logic [15:0] pll_fb_den,
   output logic pll_cfg_ok,
   // regulator and status
   output logic [1:0] core_level_code,
   output prc_mv_t core_supply_mv,
   output logic lock_status
);

   // a single stage would let a metastable lock level reach the flag
   if (SYNC_STAGES < 2)
   begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
   end

   prc_ratio_if rif();

   prc_ratio u_ratio
   (
      .rif(rif.calc)
   );

   // register file state
   logic [15:0] den;
   logic [15:0] num;
   logic [3:0] int_code;
   logic [1:0] xdiv;
   logic loop_type;
   logic pll_en;
   logic [1:0] lvl;
   logic [SYNC_STAGES-1:0] lock_sync;
   logic [15:0] next_den;
   logic [15:0] next_num;
   logic [3:0] next_int_code;
   logic [1:0] next_xdiv;
   logic next_loop_type;
   logic next_pll_en;
   logic [1:0] next_lvl;
   logic next_lock_status;
   logic [SYNC_STAGES-1:0] next_lock_sync;
   logic wr_pll;
   logic wr_reg;
   logic lock_seen;

   assign wr_pll = reg_wr && (reg_addr == PRC_ADDR_PLL);
   assign wr_reg = reg_wr && (reg_addr == PRC_ADDR_REGULATOR);
   // only the last stage is read
   assign lock_seen = lock_sync[SYNC_STAGES-1];

   always_comb
   begin
      next_den = den;
      next_num = num;
      next_int_code = int_code;
      next_xdiv = xdiv;
      next_loop_type = loop_type;
      next_pll_en = pll_en;
      next_lvl = lvl;
      next_lock_sync = {lock_sync[SYNC_STAGES-2:0], loop_locked};
      if (wr_pll)
      begin
         next_den = {reg_wdata[PLL_DEN_MSB:PLL_DEN_MID],
            reg_wdata[PLL_DEN_MID-1:PLL_DEN_LSB]};
         next_num = {reg_wdata[PLL_NUM_MSB:PLL_NUM_MID],
            reg_wdata[PLL_NUM_MID-1:PLL_NUM_LSB]};
         next_int_code = reg_wdata[PLL_INT_MSB:PLL_INT_LSB];
         next_xdiv = reg_wdata[PLL_XDIV_MSB:PLL_XDIV_LSB];
         next_loop_type = reg_wdata[PLL_TYPE_BIT];
         next_pll_en = reg_wdata[PLL_EN_BIT];
      end
      if (wr_reg)
         next_lvl = reg_wdata[REG_LVL_MSB:REG_LVL_LSB];
      // new parameters re-arm the flag; a lock seen in the same cycle wins
      if (lock_seen && pll_en)
         next_lock_status = 1'b1;
      else if (wr_pll)
         next_lock_status = 1'b0;
      else
         next_lock_status = lock_status;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         den <= PLL_DEN_RST;
         num <= PLL_NUM_RST;
         int_code <= PLL_INT_RST;
         xdiv <= PLL_XDIV_RST;
         loop_type <= PLL_TYPE_RST;
         pll_en <= PLL_EN_RST;
         lvl <= REG_LVL_RST;
         lock_status <= PLL_LOCK_RST;
         lock_sync <= '0;
      end
      else if (ce)
      begin
         den <= next_den;
         num <= next_num;
         int_code <= next_int_code;
         xdiv <= next_xdiv;
         loop_type <= next_loop_type;
         pll_en <= next_pll_en;
         lvl <= next_lvl;
         lock_status <= next_lock_status;
         lock_sync <= next_lock_sync;
      end
   end

   assign rif.r_code = int_code;
   assign rif.x_code = xdiv;
   assign rif.frac = loop_type;
   assign rif.m_den = den;
   assign rif.n_num = num;

   // registered loop controls and read port
   logic [47:0] next_rdata;
   logic next_rvalid;
   logic next_pll_run;

   always_comb
   begin
      next_rdata = 48'h0;
      next_rvalid = reg_rd;
      // an illegal ratio keeps the loop idle rather than slewing wildly
      next_pll_run = pll_en && rif.ok;
      if (reg_rd && (reg_addr == PRC_ADDR_PLL))
      begin
         next_rdata[PLL_DEN_MSB:PLL_DEN_LSB] = den;
         next_rdata[PLL_NUM_MSB:PLL_NUM_LSB] = num;
         next_rdata[PLL_INT_MSB:PLL_INT_LSB] = int_code;
         next_rdata[PLL_XDIV_MSB:PLL_XDIV_LSB] = xdiv;
         next_rdata[PLL_TYPE_BIT] = loop_type;
         next_rdata[PLL_LOCK_BIT] = lock_status;
         next_rdata[PLL_EN_BIT] = pll_en;
      end
      else if (reg_rd && (reg_addr == PRC_ADDR_REGULATOR))
         next_rdata[REG_LVL_MSB:REG_LVL_LSB] = lvl;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         reg_rdata <= 48'h0;
         reg_rvalid <= 1'b0;
         pll_run <= 1'b0;
         pll_frac <= PLL_TYPE_RST;
         pll_in_div <= 3'h1;
         pll_fb_int <= PLL_INT_RST;
         pll_fb_num <= PLL_NUM_RST;
         pll_fb_den <= PLL_DEN_RST;
         pll_cfg_ok <= 1'b0;
         core_level_code <= REG_LVL_RST;
         core_supply_mv <= prc_level_mv(REG_LVL_RST);
      end
      else if (ce)
      begin
         reg_rdata <= next_rdata;
         reg_rvalid <= next_rvalid;
         pll_run <= next_pll_run;
         pll_frac <= loop_type;
         pll_in_div <= rif.x_val;
         pll_fb_int <= rif.eff_int;
         pll_fb_num <= rif.eff_num;
         pll_fb_den <= rif.eff_den;
         pll_cfg_ok <= rif.ok;
         core_level_code <= lvl;
         core_supply_mv <= prc_level_mv(lvl);
      end
   end

   chk_lock_sets: assert property (
      @(posedge ref_clk) disable iff (reset)
      ce && lock_seen && pll_en |=> lock_status)
      else $error("lock flag not set after lock seen");

   chk_lock_sticky: assert property (
      @(posedge ref_clk) disable iff (reset)
      lock_status && !(ce && wr_pll) |=> lock_status)
      else $error("lock flag dropped without a parameter write");

   chk_lock_readonly: assert property (
      @(posedge ref_clk) disable iff (reset)
      ce && wr_pll && reg_wdata[PLL_LOCK_BIT] && !(lock_seen && pll_en)
      |=> !lock_status)
      else $error("write set the read-only lock flag");

   chk_enable_run: assert property (
      @(posedge ref_clk) disable iff (reset)
      ce && wr_pll && !reg_wdata[PLL_EN_BIT] ##1 ce |=> !pll_run)
      else $error("pll still running after disable");

   chk_level_supply: assert property (
      @(posedge ref_clk) disable iff (reset)
      ce && wr_reg ##1 ce && !wr_reg |=>
      core_supply_mv == prc_level_mv($past(reg_wdata[2:1], 2)))
      else $error("supply target does not follow level code");

   chk_den_bytes: assert property (
      @(posedge ref_clk) disable iff (reset)
      ce && wr_pll && reg_wdata[PLL_TYPE_BIT] ##1 ce && !wr_pll |=>
      pll_fb_den == $past(reg_wdata[47:32], 2))
      else $error("denominator byte order wrong");

   chk_num_bytes: assert property (
      @(posedge ref_clk) disable iff (reset)
      ce && wr_pll && reg_wdata[PLL_TYPE_BIT] ##1 ce && !wr_pll |=>
      pll_fb_num == $past(reg_wdata[31:16], 2))
      else $error("numerator byte order wrong");

   chk_int_field: assert property (
      @(posedge ref_clk) disable iff (reset)
      ce && wr_pll ##1 ce && !wr_pll |=>
      pll_fb_int == $past(reg_wdata[14:11], 2)
      && pll_in_div == 3'($past(reg_wdata[10:9], 2)) + 3'h1)
      else $error("integer or input divider field wrong");

   chk_int_mode: assert property (
      @(posedge ref_clk) disable iff (reset)
      ce && !loop_type |=> pll_fb_num == 16'h0 && pll_fb_den == 16'h1)
      else $error("integer loop kept a fraction");

endmodule

// ==== tb_top.sv ====
/*
 * Self-checking bench for the pll parameter and regulator level block.
 * Assumes prc_pkg and the design files are compiled before it.
 */
`timescale 1ns/1ps
module tb_top;
   import prc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset, ce, reg_wr, reg_rd, loop_locked;
   logic [15:0] reg_addr;
   logic [47:0] reg_wdata, reg_rdata, last_d;
   logic reg_rvalid, pll_run, pll_frac, pll_cfg_ok, lock_status, exp_lock;
   logic [2:0] pll_in_div;
   logic [3:0] pll_fb_int;
   logic [15:0] pll_fb_num, pll_fb_den;
   logic [1:0] core_level_code;
   prc_mv_t core_supply_mv;
   logic [47:0] exp_q[$];
   logic [10:0] mv_tab[4] = '{11'h5dc, 11'h578, 11'h640, 11'h6a4};
   integer seed = 32'h0fbf;
   int n_errors = 0;
   int compares = 0;

   prc_top prc_top_i (.ref_clk(ref_clk), .reset(reset), .ce(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .loop_locked(loop_locked), .pll_run(pll_run), .pll_frac(pll_frac),
      .pll_in_div(pll_in_div), .pll_fb_int(pll_fb_int),
      .pll_fb_num(pll_fb_num), .pll_fb_den(pll_fb_den),
      .pll_cfg_ok(pll_cfg_ok), .core_level_code(core_level_code),
      .core_supply_mv(core_supply_mv), .lock_status(lock_status));

   always #5 ref_clk = ~ref_clk;

   task automatic give_verdict;
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp_read(input logic [47:0] e, input logic [47:0] s);
      compares++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD reg_rdata exp %h got %h", e, s);
      end
   endtask

   task automatic cmp_out(input string what, input logic [15:0] e,
      input logic [15:0] s);
      compares++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", what, e, s);
      end
   endtask

   // reserved bits read zero, the lock bit shows the flag, not the write
   function automatic logic [47:0] pll_img(input logic [47:0] d);
      return {d[47:16], 1'b0, d[14:8], 6'h00, exp_lock, d[0]};
   endfunction

   task automatic wr(input logic [15:0] a, input logic [47:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [47:0] e);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      exp_q.push_back(e);
      @(negedge ref_clk);
      reg_rd = 1'b0;
   endtask

   task automatic pll_set(input logic [47:0] d);
      logic [3:0] r;
      logic fr;
      logic ok;
      r = d[14:11];
      fr = d[8];
      ok = (r >= 4'h2) && (r <= 4'h8) && (!fr || d[47:32] != 16'h0);
      wr(PRC_ADDR_PLL, d);
      last_d = d;
      @(negedge ref_clk);
      cmp_out("run", 16'(ok & d[0]), 16'(pll_run));
      cmp_out("cfg_ok", 16'(ok), 16'(pll_cfg_ok));
      cmp_out("frac", 16'(fr), 16'(pll_frac));
      cmp_out("in_div", 16'(d[10:9]) + 16'h1, 16'(pll_in_div));
      cmp_out("fb_int", 16'(r), 16'(pll_fb_int));
      cmp_out("fb_num", fr ? d[31:16] : 16'h0, pll_fb_num);
      cmp_out("fb_den", fr ? d[47:32] : 16'h1, pll_fb_den);
      cmp_out("lock", 16'(exp_lock), 16'(lock_status));
      rd(PRC_ADDR_PLL, pll_img(d));
   endtask

   // read data is checked in the cycle its valid strobe stands
   always @(negedge ref_clk)
   begin
      if (reg_rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            cmp_read(48'h0, 48'hx);
         else
            cmp_read(exp_q.pop_front(), reg_rdata);
      end
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      give_verdict();
   end

   initial
   begin
      reset = 1'b1;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0;
      reg_wdata = 48'h0;
      loop_locked = 1'b0;
      exp_lock = 1'b0;
      repeat (12) @(negedge ref_clk);
      reset = 1'b0;
      rd(PRC_ADDR_PLL, 48'h0753_0287_1901);
      rd(PRC_ADDR_REGULATOR, 48'h2);
      cmp_out("level", 16'h1, 16'(core_level_code));
      cmp_out("lock", 16'h0, 16'(lock_status));
      for (int i = 0; i < 4; i++)
      begin
         wr(PRC_ADDR_REGULATOR, {$random(seed), 13'($random(seed)), 2'(i),
            1'($random(seed))});
         @(negedge ref_clk);
         cmp_out("level", 16'(i), 16'(core_level_code));
         cmp_out("mv", 16'(mv_tab[i]), 16'(core_supply_mv));
         rd(PRC_ADDR_REGULATOR, 48'(i << 1));
      end
      // ce low: the write must not land
      @(negedge ref_clk);
      ce = 1'b0;
      wr(PRC_ADDR_REGULATOR, 48'h0);
      ce = 1'b1;
      rd(PRC_ADDR_REGULATOR, 48'h6);
      pll_set({16'h007d, 16'h000c, 16'h2103});
      pll_set({16'h007d, 16'h000c, 16'h2001});
      pll_set({16'h0000, 16'h0005, 16'h4101});
      pll_set({16'hffff, 16'hffff, 16'h0b00});
      pll_set({16'h0001, 16'h0000, 16'h0901});
      pll_set({16'h0001, 16'h0000, 16'h1101});
      for (int i = 0; i < 16; i++)
         pll_set({$random(seed), 16'($random(seed))});
      // write and read in one cycle: the read sees the old contents
      @(negedge ref_clk);
      reg_addr = PRC_ADDR_PLL;
      reg_wdata = 48'h0003_0001_2301;
      reg_wr = 1'b1;
      reg_rd = 1'b1;
      exp_q.push_back(pll_img(last_d));
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      last_d = 48'h0003_0001_2301;
      rd(PRC_ADDR_PLL, 48'h0003_0001_2301);
      wr(16'h4003, 48'hffff_ffff_ffff);
      rd(16'h4003, 48'h0);
      rd(PRC_ADDR_PLL, 48'h0003_0001_2301);
      // sticky lock: set by the loop, kept after it drops
      @(negedge ref_clk);
      loop_locked = 1'b1;
      repeat (4) @(negedge ref_clk);
      loop_locked = 1'b0;
      repeat (4) @(negedge ref_clk);
      cmp_out("lock", 16'h1, 16'(lock_status));
      exp_lock = 1'b1;
      rd(PRC_ADDR_PLL, pll_img(last_d));
      exp_lock = 1'b0;
      pll_set({16'h007d, 16'h000c, 16'h2000});
      @(negedge ref_clk);
      loop_locked = 1'b1;
      repeat (6) @(negedge ref_clk);
      cmp_out("lock", 16'h0, 16'(lock_status));
      loop_locked = 1'b0;
      repeat (3) @(negedge ref_clk);
      // mid-run reset brings every field back to its default
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      rd(PRC_ADDR_PLL, 48'h0753_0287_1901);
      rd(PRC_ADDR_REGULATOR, 48'h2);
      cmp_out("level", 16'h1, 16'(core_level_code));
      cmp_out("mv", 16'(mv_tab[1]), 16'(core_supply_mv));
      if (exp_q.size() != 0)
         cmp_read(48'h0, 48'hx);
      give_verdict();
   end
endmodule
